// File: src/ccd_regs.vh
`ifndef CCD_REGS_VH
`define CCD_REGS_VH
`define CCD_ADDR_W          10
`define CCD_OFF_COUNTS      10'h199
`define CCD_OFF_CTRL        10'h19a
`define CCD_OFF_ROUTE       10'h19b
`define CCD_OFF_PRESCALE    10'h1e0
`define CCD_OFF_CLKIN       10'h1e1
`define CCD_LOW_HI          7
`define CCD_LOW_LO          4
`define CCD_HIGH_HI         3
`define CCD_HIGH_LO         0
`define CCD_BIT_BYPASS      7
`define CCD_BIT_IGN_ALIGN   6
`define CCD_BIT_FORCE       5
`define CCD_BIT_START_HIGH  4
`define CCD_PHASE_HI        3
`define CCD_PHASE_LO        0
`define CCD_BIT_PWRDN       2
`define CCD_BIT_DIRECT      1
`define CCD_BIT_DUTY_OFF    0
`define CCD_BIT_SEL_OSC     1
`define CCD_BIT_PRE_BYPASS  0
`define CCD_RST_COUNTS      8'h00
`define CCD_RST_CTRL        8'h00
`define CCD_RST_ROUTE       8'h00
`define CCD_RST_PRESCALE    8'h00
`define CCD_RST_CLKIN       8'h00
`define CCD_SEL_EXT         2'b00
`define CCD_SEL_NONE        2'b01
`define CCD_SEL_OSC         2'b10
`endif

// File: src/ccd_prescaler.v
`timescale 1ns/10ps
`include "ccd_regs.vh"
// divides the selected source by 2..5, emits a one-cycle enable per output period
module ccd_prescaler
(
	input  wire       ref_clk,
	input  wire       rstn,
	input  wire       src_tick,
	input  wire [2:0] ratio_code,
	input  wire       bypass,
	output reg        pre_tick
);
	reg  [2:0] cnt_q;
	wire [2:0] last;

	// reserved codes above 011 fall back to divide by 2
	assign last = ratio_code[2] ? 3'h1 : ratio_code + 3'h1;

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q    <= 3'h0;
			pre_tick <= 1'b0;
		end
		else if (bypass)
		begin
			cnt_q    <= 3'h0;
			pre_tick <= src_tick;
		end
		else
		begin
			pre_tick <= 1'b0;
			if (src_tick)
			begin
				if (cnt_q >= last)
				begin
					cnt_q    <= 3'h0;
					pre_tick <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 3'h1;
			end
		end
	end
endmodule // ccd_prescaler

// File: src/ccd_divider.v
`timescale 1ns/10ps
`include "ccd_regs.vh"
// high/low counting divider stepped by tick; align restarts after phase delay
module ccd_divider
(
	input  wire       ref_clk,
	input  wire       rstn,
	input  wire       tick,
	input  wire [3:0] low_cnt,
	input  wire [3:0] high_cnt,
	input  wire       start_high,
	input  wire [3:0] phase,
	input  wire       align,
	input  wire       hold,
	output reg        div_out
);
	reg  [3:0] cnt_q;
	reg  [4:0] wait_q;
	reg        waiting_q;

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q     <= 4'h0;
			wait_q    <= 5'h00;
			waiting_q <= 1'b0;
			div_out   <= 1'b0;
		end
		else if (hold)
		begin
			cnt_q     <= 4'h0;
			waiting_q <= 1'b0;
			div_out   <= start_high;
		end
		else if (align)
		begin
			cnt_q     <= 4'h0;
			wait_q    <= {1'b0, phase};
			waiting_q <= 1'b1;
			div_out   <= start_high;
		end
		else if (tick)
		begin
			if (waiting_q)
			begin
				if (wait_q == 5'h00)
					waiting_q <= 1'b0;
				else
					wait_q <= wait_q - 5'h01;
			end
			else if (div_out && cnt_q >= high_cnt)
			begin
				cnt_q   <= 4'h0;
				div_out <= 1'b0;
			end
			else if (!div_out && cnt_q >= low_cnt)
			begin
				cnt_q   <= 4'h0;
				div_out <= 1'b1;
			end
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // ccd_divider

// File: src/ccd_channel.v
`timescale 1ns/10ps
`include "ccd_regs.vh"
// Behaviour
// - output stays low for low-count field plus one input cycles.
// - output stays high for high-count field plus one input cycles.
// - bypass bit outputs the prescaled clock as a level, the divider keeps running unused unless the force bit holds it.
// - alignment is obeyed unless the ignore bit is set.
// - force bit has no effect while the divider is bypassed.
// - force low when start-level bit 0, else force high.
// - start-level bit sets the level toggling begins from.
// - a four-bit phase offset field, default zero.
// - power-down bit puts all three group outputs into safe low state.
// - direct route takes oscillator on 10b, external on 00b, divider output on 01b and 11b.
// - duty correction on when its disable bit is zero.
// - prescaler divides by 2, 3, 4 or 5 for codes 000..011.
// - input select picks external clock at 0, oscillator at 1.
// - prescaler bypass skips it; bypass is ignored while the oscillator is chosen.
module ccd_channel
(
	input  wire       ref_clk,
	input  wire       rstn,
	input  wire       ext_clk,
	input  wire       osc_clk,
	input  wire       align_n,
	input  wire [9:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	output reg        group3_out_a,
	output reg        group3_out_b,
	output reg        group3_out_c,
	output reg        group3_dead,
	output wire       duty_fix
);
	reg  [7:0] counts_q;
	reg  [7:0] ctrl_q;
	reg  [7:0] route_q;
	reg  [7:0] pre_q;
	reg  [7:0] clkin_q;
	reg  [2:0] ext_sync_q;
	reg  [2:0] osc_sync_q;
	reg  [2:0] align_sync_q;
	reg        ext_lvl_q;
	reg        osc_lvl_q;
	reg        align_lvl_q;
	reg        chan_clk;
	wire       sel_osc;
	wire       pre_bypass;
	wire       ext_rise;
	wire       osc_rise;
	wire       ext_chg;
	wire       osc_chg;
	wire       src_tick;
	wire       pre_tick;
	wire       align_evt;
	wire       div_out;
	wire       force_hold;
	reg        chan_d;
	reg        outs_d;
	reg        pre_lvl_q;

	function hit;
		input [9:0] a;
		input [9:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			counts_q <= `CCD_RST_COUNTS;
			ctrl_q   <= `CCD_RST_CTRL;
			route_q  <= `CCD_RST_ROUTE;
			pre_q    <= `CCD_RST_PRESCALE;
			clkin_q  <= `CCD_RST_CLKIN;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, `CCD_OFF_COUNTS))
				counts_q <= reg_wdata;
			if (hit(reg_addr, `CCD_OFF_CTRL))
				ctrl_q <= reg_wdata;
			if (hit(reg_addr, `CCD_OFF_ROUTE))
				route_q <= {5'h00, reg_wdata[2:0]};
			if (hit(reg_addr, `CCD_OFF_PRESCALE))
				pre_q <= {5'h00, reg_wdata[2:0]};
			if (hit(reg_addr, `CCD_OFF_CLKIN))
				clkin_q <= {6'h00, reg_wdata[1:0]};
		end
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (hit(reg_addr, `CCD_OFF_COUNTS))
				reg_rdata <= counts_q;
			else if (hit(reg_addr, `CCD_OFF_CTRL))
				reg_rdata <= ctrl_q;
			else if (hit(reg_addr, `CCD_OFF_ROUTE))
				reg_rdata <= route_q;
			else if (hit(reg_addr, `CCD_OFF_PRESCALE))
				reg_rdata <= pre_q;
			else if (hit(reg_addr, `CCD_OFF_CLKIN))
				reg_rdata <= clkin_q;
			else
				reg_rdata <= 8'h00;
		end
	end

	// three-stage synchronisers; a change counts once stages two and three agree
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_sync_q   <= 3'h0;
			osc_sync_q   <= 3'h0;
			align_sync_q <= 3'h7;
			ext_lvl_q    <= 1'b0;
			osc_lvl_q    <= 1'b0;
			align_lvl_q  <= 1'b1;
		end
		else
		begin
			ext_sync_q   <= {ext_sync_q[1:0], ext_clk};
			osc_sync_q   <= {osc_sync_q[1:0], osc_clk};
			align_sync_q <= {align_sync_q[1:0], align_n};
			if (ext_sync_q[1] == ext_sync_q[2])
				ext_lvl_q <= ext_sync_q[2];
			if (osc_sync_q[1] == osc_sync_q[2])
				osc_lvl_q <= osc_sync_q[2];
			if (align_sync_q[1] == align_sync_q[2])
				align_lvl_q <= align_sync_q[2];
		end
	end

	assign ext_chg  = (ext_sync_q[1] == ext_sync_q[2]) && (ext_sync_q[2] != ext_lvl_q);
	assign osc_chg  = (osc_sync_q[1] == osc_sync_q[2]) && (osc_sync_q[2] != osc_lvl_q);
	assign ext_rise = ext_chg && ext_sync_q[2];
	assign osc_rise = osc_chg && osc_sync_q[2];

	// the oscillator cannot be used bypassed, so choosing it overrides the bypass bit
	assign pre_bypass = clkin_q[`CCD_BIT_PRE_BYPASS] & ~clkin_q[`CCD_BIT_SEL_OSC];
	assign sel_osc    = clkin_q[`CCD_BIT_SEL_OSC];
	assign src_tick   = sel_osc ? osc_rise : ext_rise;

	ccd_prescaler u_pre
	(
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.src_tick   (src_tick),
		.ratio_code (pre_q[2:0]),
		.bypass     (pre_bypass),
		.pre_tick   (pre_tick)
	);

	// prescaled clock as a level: toggles once per prescaler period
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			pre_lvl_q <= 1'b0;
		else if (pre_tick)
			pre_lvl_q <= ~pre_lvl_q;
	end

	// falling edge of the active-low alignment line, gated by ignore bit
	assign align_evt  = align_lvl_q & (align_sync_q[1] == align_sync_q[2])
		& ~align_sync_q[2] & ~ctrl_q[`CCD_BIT_IGN_ALIGN];
	assign force_hold = ctrl_q[`CCD_BIT_FORCE] | ~ctrl_q[`CCD_BIT_IGN_ALIGN] & 1'b0;

	ccd_divider u_div
	(
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.tick       (pre_tick),
		.low_cnt    (counts_q[`CCD_LOW_HI:`CCD_LOW_LO]),
		.high_cnt   (counts_q[`CCD_HIGH_HI:`CCD_HIGH_LO]),
		.start_high (ctrl_q[`CCD_BIT_START_HIGH]),
		.phase      (ctrl_q[`CCD_PHASE_HI:`CCD_PHASE_LO]),
		.align      (align_evt),
		.hold       (force_hold),
		.div_out    (div_out)
	);

	always @*
	begin
		if (ctrl_q[`CCD_BIT_BYPASS])
			chan_d = pre_lvl_q;
		else if (ctrl_q[`CCD_BIT_FORCE])
			chan_d = ctrl_q[`CCD_BIT_START_HIGH];
		else
			chan_d = div_out;
	end

	always @*
	begin
		outs_d = chan_d;
		if (route_q[`CCD_BIT_DIRECT])
		begin
			case (clkin_q[1:0])
				`CCD_SEL_OSC: outs_d = osc_lvl_q;
				`CCD_SEL_EXT: outs_d = ext_lvl_q;
				default:      outs_d = chan_d;
			endcase
		end
		if (route_q[`CCD_BIT_PWRDN])
			outs_d = 1'b0;
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			group3_out_a <= 1'b0;
			group3_out_b <= 1'b0;
			group3_out_c <= 1'b0;
			group3_dead  <= 1'b0;
		end
		else
		begin
			group3_out_a <= outs_d;
			group3_out_b <= outs_d;
			group3_out_c <= outs_d;
			group3_dead  <= route_q[`CCD_BIT_PWRDN];
		end
	end

	assign duty_fix = ~route_q[`CCD_BIT_DUTY_OFF];
endmodule // ccd_channel

// File: tb/ccd_monitor.sv
`timescale 1ns/10ps
module ccd_monitor
(
	input wire       ref_clk,
	input wire       rstn,
	input wire [9:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       group3_out_a,
	input wire       group3_out_b,
	input wire       group3_out_c,
	input wire       group3_dead,
	input wire       duty_fix
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire wr_rt = reg_wr && reg_addr == 10'h19b;
	property p_same; group3_out_b == group3_out_a && group3_out_c == group3_out_a; endproperty
	a_same: assert property (p_same) else $error("outputs differ");
	property p_dead; group3_dead && $past(group3_dead) |-> !group3_out_a; endproperty
	a_dead: assert property (p_dead) else $error("output live in power-down");
	property p_pd_on; wr_rt && reg_wdata[2] |-> ##[1:3] group3_dead; endproperty
	a_pd_on: assert property (p_pd_on) else $error("no power-down");
	property p_pd_off; wr_rt && !reg_wdata[2] |-> ##[1:3] !group3_dead; endproperty
	a_pd_off: assert property (p_pd_off) else $error("power-down stuck");
	property p_duty; wr_rt |=> duty_fix == !$past(reg_wdata[0]); endproperty
	a_duty: assert property (p_duty) else $error("duty flag wrong");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; reg_rd && reg_addr[9:8] == 2'b00 |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
	property p_pre; reg_rd && reg_addr == 10'h1e0 |=> reg_rdata[7:3] == 5'h00; endproperty
	a_pre: assert property (p_pre) else $error("prescaler spare bits set");
	property p_cnt;
		reg_wr && reg_addr == 10'h199 ##2 reg_rd && reg_addr == 10'h199
		|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_cnt: assert property (p_cnt) else $error("counts readback wrong");
	c_dead: cover property (group3_dead);
	c_rise: cover property ($rose(group3_out_a));
	c_unmap: cover property (reg_rd && reg_addr[9:8] == 2'b00);
endmodule // ccd_monitor

bind ccd_channel ccd_monitor u_mon
(
	.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.group3_out_a(group3_out_a), .group3_out_b(group3_out_b),
	.group3_out_c(group3_out_c), .group3_dead(group3_dead), .duty_fix(duty_fix)
);

// File: tb/channel_clock_divider_test.sv
`timescale 1ns/10ps
module channel_clock_divider_test;
	reg        ref_clk, rstn, ext_clk, osc_clk, align_n, reg_wr, reg_rd;
	reg  [9:0] reg_addr;
	reg  [7:0] reg_wdata;
	wire [7:0] reg_rdata;
	wire       out_a, out_b, out_c, dead, duty;
	integer    bad_count, total_checks;
	ccd_channel uut
	(
		.ref_clk(ref_clk), .rstn(rstn), .ext_clk(ext_clk), .osc_clk(osc_clk),
		.align_n(align_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .group3_out_a(out_a),
		.group3_out_b(out_b), .group3_out_c(out_c), .group3_dead(dead), .duty_fix(duty)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// ext period 8 cycles, osc 10; edges kept clear of ref_clk edges
	initial
	begin
		ext_clk = 1'b0;
		#7;
		forever #160 ext_clk = ~ext_clk;
	end
	initial
	begin
		osc_clk = 1'b0;
		#13;
		forever #200 osc_clk = ~osc_clk;
	end
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input [15:0] got, input [15:0] exp, input string m);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
		end
	end
	endtask
	// trailing idle cycle keeps two writes from sharing a time step
	task wr(input [9:0] a, input [7:0] d);
	begin
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
		@(posedge ref_clk);
		#1;
	end
	endtask
	task rd(input [9:0] a, input [7:0] e);
	begin
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		@(posedge ref_clk);
		#1 chk(reg_rdata, e, "read");
	end
	endtask
	task span(input lvl, output integer c);
	begin
		c = 0;
		while (out_a === lvl && c < 500)
		begin
			@(posedge ref_clk);
			#1 c = c + 1;
		end
		if (c >= 500)
		begin
			bad_count = bad_count + 1;
			$display("mismatch at %0t: output stuck", $time);
			end_sim;
		end
	end
	endtask
	// first two spans may be partial after a reconfiguration
	task meas(input integer eh, input integer el);
		integer h, l;
	begin
		repeat (100) @(posedge ref_clk);
		#1 span(1'b1, h);
		span(1'b0, l);
		span(1'b1, h);
		span(1'b0, l);
		chk(h[15:0], eh[15:0], "high span");
		chk(l[15:0], el[15:0], "low span");
	end
	endtask
	task steady(input lvl);
	begin
		repeat (100) @(posedge ref_clk);
		repeat (20)
		begin
			@(posedge ref_clk);
			#1 chk(out_a, lvl, "forced level");
		end
	end
	endtask
	task t_reset;
	begin
		chk(duty, 1'b1, "duty at reset");
		rd(10'h199, 8'h00);
		rd(10'h19a, 8'h00);
		rd(10'h19b, 8'h00);
		rd(10'h1e0, 8'h00);
		rd(10'h1e1, 8'h00);
		rd(10'h000, 8'h00);
	end
	endtask
	task t_regs;
	begin
		wr(10'h199, 8'ha5);
		rd(10'h199, 8'ha5);
		wr(10'h19b, 8'hff);
		rd(10'h19b, 8'h07);
		chk(dead, 1'b1, "dead flag");
		chk(out_a, 1'b0, "powered-down output");
		chk(duty, 1'b0, "duty disabled");
		wr(10'h19b, 8'h00);
		wr(10'h1e0, 8'hff);
		rd(10'h1e0, 8'h07);
	end
	endtask
	task t_ratio;
		integer k;
	begin
		wr(10'h199, 8'h21);
		for (k = 0; k < 4; k = k + 1)
		begin
			wr(10'h1e0, k[7:0]);
			meas(16 * (k + 2), 24 * (k + 2));
		end
		wr(10'h1e0, 8'h00);
		wr(10'h19a, 8'he0);
		meas(16, 16);
		wr(10'h19a, 8'h70);
		steady(1'b1);
		wr(10'h19a, 8'h60);
		steady(1'b0);
		wr(10'h19a, 8'h00);
	end
	endtask
	task t_route;
	begin
		wr(10'h1e1, 8'h02);
		wr(10'h19b, 8'h02);
		meas(5, 5);
		wr(10'h1e1, 8'h00);
		meas(4, 4);
		wr(10'h1e1, 8'h01);
		meas(16, 24);
	end
	endtask
	// phase f holds start level about 17 ticks after an obeyed event
	task t_align;
		integer c;
		reg     v;
	begin
		wr(10'h1e1, 8'h00);
		wr(10'h19b, 8'h00);
		wr(10'h199, 8'h00);
		wr(10'h19a, 8'h5f);
		repeat (50) @(posedge ref_clk);
		#1 align_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1 v = out_a;
		c = 0;
		while (out_a === v && c < 40)
		begin
			@(posedge ref_clk);
			#1 c = c + 1;
		end
		chk(c < 40, 1'b1, "ignored align held output");
		align_n = 1'b1;
		wr(10'h19a, 8'h1f);
		repeat (50) @(posedge ref_clk);
		#1 align_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		repeat (20)
		begin
			repeat (10) @(posedge ref_clk);
			#1 chk(out_a, 1'b1, "align start level");
		end
		align_n = 1'b1;
		wr(10'h19a, 8'h00);
	end
	endtask
	initial
	begin
		bad_count = 0;
		total_checks = 0;
		rstn = 1'b0;
		align_n = 1'b1;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 rstn = 1'b1;
		t_reset;
		t_regs;
		t_ratio;
		t_route;
		t_align;
		end_sim;
	end
endmodule // channel_clock_divider_test
